// [irq_seq.sv]
`default_nettype none
module irq_seq
	import irq_seq_pkg::*;
#(
	parameter int PORT_PINS = 4
) (
	input  wire logic                 clk_sys_i,
	input  wire logic                 sys_rst_i,
	input  wire logic [3:0]           s_axi_awaddr_i,
	input  wire logic                 s_axi_awvalid_i,
	output logic                      s_axi_awready_o,
	input  wire logic [31:0]          s_axi_wdata_i,
	input  wire logic [3:0]           s_axi_wstrb_i,
	input  wire logic                 s_axi_wvalid_i,
	output logic                      s_axi_wready_o,
	output logic [1:0]                s_axi_bresp_o,
	output logic                      s_axi_bvalid_o,
	input  wire logic                 s_axi_bready_i,
	input  wire logic [3:0]           s_axi_araddr_i,
	input  wire logic                 s_axi_arvalid_i,
	output logic                      s_axi_arready_o,
	output logic [31:0]               s_axi_rdata_o,
	output logic [1:0]                s_axi_rresp_o,
	output logic                      s_axi_rvalid_o,
	input  wire logic                 s_axi_rready_i,
	input  wire logic                 power_on_i,
	input  wire logic                 reset_pin_n_i,
	input  wire logic                 low_voltage_i,
	input  wire logic                 illegal_addr_i,
	input  wire logic                 watchdog_timeout_i,
	input  wire logic                 ext_request_n_i,
	input  wire logic [PORT_PINS-1:0] port_request_pins_i,
	input  wire periph_req_s          periph_req_i,
	input  wire logic                 inst_done_i,
	input  wire logic                 software_trap_i,
	input  wire logic                 return_from_trap_i,
	input  wire logic                 clear_mask_instruction_i,
	input  wire logic                 saved_mask_i,
	output logic                      core_reset_o,
	output core_cmd_s                 core_cmd_o,
	output logic                      global_mask_o,
	output logic                      busy_o
);
	if (PORT_PINS < 1 || PORT_PINS > 8) begin : g_check
		$error("PORT_PINS must be 1 to 8");
	end

	seq_state_e             state_reg;
	logic [2:0]             cnt_reg;
	logic [12:0]            vec_reg;
	logic                   global_mask_reg;
	logic                   core_reset_reg;
	logic                   rst_vec_pend_reg;
	logic                   ext_request_enable_reg;
	logic                   ext_request_flag_reg;
	logic [2:0]             opt_reg;
	logic                   irq_meta_reg;
	logic                   irq_sync_reg;
	logic [PORT_PINS-1:0]   pa_meta_reg;
	logic [PORT_PINS-1:0]   pa_sync_reg;
	logic                   comb_prev_reg;
	logic                   comb_req;
	logic                   ext_set;
	logic                   ext_clr;
	logic                   ext_go;
	logic                   any_reset;
	logic                   at_boundary;
	logic                   last_byte;
	logic                   aw_hold_reg;
	logic                   w_hold_reg;
	logic [3:0]             aw_addr_reg;
	logic [31:0]            w_data_reg;
	logic                   w_strb0_reg;
	logic                   bvalid_reg;
	logic [1:0]             bresp_reg;
	logic                   rvalid_reg;
	logic [31:0]            rdata_reg;
	logic [1:0]             rresp_reg;
	logic                   wr_fire;
	logic                   rd_fire;
	logic [12:0]            periph_vec;

	// ************************************************************
	// Reset sources
	// ************************************************************
	assign any_reset = power_on_i | ~reset_pin_n_i | low_voltage_i | illegal_addr_i
		| (watchdog_timeout_i & opt_reg[OPT_WD_BIT]);

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			core_reset_reg <= 1'b1;
		end else begin
			core_reset_reg <= any_reset;
		end
	end

	// The reset vector is fetched once, right after any reset source lets go
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || core_reset_reg) begin
			rst_vec_pend_reg <= 1'b1;
		end else if (state_reg == ST_IDLE) begin
			rst_vec_pend_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Request pin and port pin synchronisers
	// ************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_meta_reg <= 1'b1;
			irq_sync_reg <= 1'b1;
		end else begin
			irq_meta_reg <= ext_request_n_i;
			irq_sync_reg <= irq_meta_reg;
		end
	end

	for (genvar i = 0; i < PORT_PINS; i++) begin : g_port_sync
		always_ff @(posedge clk_sys_i) begin
			if (sys_rst_i) begin
				pa_meta_reg[i] <= 1'b0;
				pa_sync_reg[i] <= 1'b0;
			end else begin
				pa_meta_reg[i] <= port_request_pins_i[i];
				pa_sync_reg[i] <= pa_meta_reg[i];
			end
		end
	end

	// ************************************************************
	// External request latch
	// ************************************************************
	// All sources merge onto one line, so while any of them is asserted
	// no other can produce a fresh edge: that is the intended hiding.
	assign comb_req = ~irq_sync_reg | (opt_reg[OPT_PORT_BIT] & (|pa_sync_reg));
	assign ext_set  = (comb_req & ~comb_prev_reg)
		| (opt_reg[OPT_LEVEL_BIT] & comb_req);
	assign ext_clr  = ((state_reg == ST_FETCH) && (vec_reg == VEC_EXT))
		|| (wr_fire && w_strb0_reg && aw_addr_reg == ADDR_ISC
			&& w_data_reg[ISC_CLR_BIT]);
	assign ext_go   = ext_request_flag_reg & ~global_mask_reg
		& ext_request_enable_reg;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			comb_prev_reg <= 1'b0;
		end else begin
			comb_prev_reg <= comb_req;
		end
	end
	// A new request in the clearing cycle survives the clear
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || core_reset_reg) begin
			ext_request_flag_reg <= 1'b0;
		end else begin
			ext_request_flag_reg <= ext_set | (ext_request_flag_reg & ~ext_clr);
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || core_reset_reg) begin
			ext_request_enable_reg <= 1'b1;
		end else if (wr_fire && w_strb0_reg && aw_addr_reg == ADDR_ISC) begin
			ext_request_enable_reg <= w_data_reg[ISC_EN_BIT];
		end
	end

	// Option bits survive core resets so the watchdog option stays in force
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			opt_reg <= OPT_RESET;
		end else if (wr_fire && w_strb0_reg && aw_addr_reg == ADDR_OPT) begin
			opt_reg <= w_data_reg[2:0];
		end
	end

	// ************************************************************
	// Entry and return sequencer
	// ************************************************************
	assign at_boundary = (state_reg == ST_IDLE) && inst_done_i && !rst_vec_pend_reg;
	assign last_byte   = (cnt_reg == STACK_BYTES - 3'h1);
	assign periph_vec  = periph_req_i.core_timer ? VEC_CTMR
		: periph_req_i.prog_timer ? VEC_PTMR
		: periph_req_i.serial ? VEC_SER : VEC_ANA;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || core_reset_reg) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 3'h0;
			vec_reg   <= VEC_RESET;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					cnt_reg <= 3'h0;
					if (rst_vec_pend_reg) begin
						vec_reg   <= VEC_RESET;
						state_reg <= ST_FETCH;
					end else if (at_boundary) begin
						// Priority chain, highest first
						if (return_from_trap_i) begin
							state_reg <= ST_POP;
						end else if (software_trap_i) begin
							vec_reg   <= VEC_TRAP;
							state_reg <= ST_PUSH;
						end else if (ext_go) begin
							vec_reg   <= VEC_EXT;
							state_reg <= ST_PUSH;
						end else if (!global_mask_reg && (|periph_req_i)) begin
							vec_reg   <= periph_vec;
							state_reg <= ST_PUSH;
						end
					end
				end
				ST_PUSH, ST_POP: begin
					cnt_reg <= cnt_reg + 3'h1;
					if (last_byte) begin
						state_reg <= (state_reg == ST_PUSH) ? ST_FETCH : ST_IDLE;
					end
				end
				ST_FETCH: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Mask is set after stacking so the stacked copy keeps the old value
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || core_reset_reg) begin
			global_mask_reg <= 1'b1;
		end else if (state_reg == ST_PUSH && last_byte) begin
			global_mask_reg <= 1'b1;
		end else if (state_reg == ST_POP && last_byte) begin
			global_mask_reg <= saved_mask_i;
		end else if (at_boundary && clear_mask_instruction_i) begin
			global_mask_reg <= 1'b0;
		end
	end

	assign core_cmd_o.push     = (state_reg == ST_PUSH);
	assign core_cmd_o.pop      = (state_reg == ST_POP);
	assign core_cmd_o.fetch    = (state_reg == ST_FETCH);
	assign core_cmd_o.vec_addr = vec_reg;
	assign core_reset_o        = core_reset_reg;
	assign global_mask_o       = global_mask_reg;
	assign busy_o              = (state_reg != ST_IDLE) || rst_vec_pend_reg;

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	assign s_axi_awready_o = ~aw_hold_reg & ~bvalid_reg;
	assign s_axi_wready_o  = ~w_hold_reg & ~bvalid_reg;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_arready_o = ~rvalid_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign s_axi_rresp_o   = rresp_reg;
	assign wr_fire         = aw_hold_reg & w_hold_reg & ~bvalid_reg;
	assign rd_fire         = s_axi_arvalid_i & ~rvalid_reg;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
		end else if (s_axi_awvalid_i && s_axi_awready_o) begin
			aw_hold_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr_i;
		end else if (wr_fire) begin
			aw_hold_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			w_hold_reg  <= 1'b0;
			w_data_reg  <= 32'h0;
			w_strb0_reg <= 1'b0;
		end else if (s_axi_wvalid_i && s_axi_wready_o) begin
			w_hold_reg  <= 1'b1;
			w_data_reg  <= s_axi_wdata_i;
			w_strb0_reg <= s_axi_wstrb_i[0];
		end else if (wr_fire) begin
			w_hold_reg <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= (aw_addr_reg == ADDR_ISC || aw_addr_reg == ADDR_OPT
				|| aw_addr_reg == ADDR_STAT) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Clear bit always reads zero; unused bits read zero
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= 32'h0;
			rresp_reg  <= RESP_OKAY;
			case (s_axi_araddr_i)
				ADDR_ISC: begin
					rdata_reg[ISC_EN_BIT]   <= ext_request_enable_reg;
					rdata_reg[ISC_FLAG_BIT] <= ext_request_flag_reg;
				end
				ADDR_OPT: begin
					rdata_reg[2:0] <= opt_reg;
				end
				ADDR_STAT: begin
					rdata_reg[STAT_MASK_BIT] <= global_mask_reg;
					rdata_reg[STAT_BUSY_BIT] <= busy_o;
				end
				default: begin
					rresp_reg <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);

	AST_NO_MID_INSTR: assert property (
		(state_reg == ST_IDLE && !inst_done_i && !rst_vec_pend_reg && !core_reset_reg)
		|=> state_reg == ST_IDLE) else $error("left idle mid instruction");
	// Trap entry may start masked, so the mask is checked only from the first push: it stays put while stacking and is set at fetch
	AST_ENTRY_ORDER: assert property (
		(state_reg == ST_PUSH && $past(state_reg) == ST_IDLE && !any_reset && !core_reset_reg)
		|=> (state_reg == ST_PUSH && $stable(global_mask_reg))[*4]
		##1 (state_reg == ST_FETCH && global_mask_reg)) else $error("bad entry sequence");
	AST_RTI_RESTORE: assert property (
		(state_reg == ST_POP && last_byte && !core_reset_reg)
		|=> global_mask_reg == $past(saved_mask_i)) else $error("mask not restored");
	AST_RESET_VECTOR: assert property (
		($fell(core_reset_reg) && !any_reset)
		|=> (state_reg == ST_FETCH && vec_reg == VEC_RESET)) else $error("no reset fetch");
	AST_WD_GATED: assert property (
		(watchdog_timeout_i && !opt_reg[OPT_WD_BIT] && !power_on_i && reset_pin_n_i
		&& !low_voltage_i && !illegal_addr_i) |=> !core_reset_reg) else $error("ungated watchdog");
	AST_TRAP_FIRST: assert property (
		(at_boundary && software_trap_i && !return_from_trap_i && !core_reset_reg)
		|=> (state_reg == ST_PUSH && vec_reg == VEC_TRAP)) else $error("trap not taken");
	AST_EXT_GATED: assert property (
		(state_reg == ST_PUSH && $past(state_reg) == ST_IDLE && vec_reg == VEC_EXT)
		|-> $past(!global_mask_reg && ext_request_enable_reg && ext_request_flag_reg))
		else $error("external vector taken while blocked");
	AST_FETCH_CLEARS: assert property (
		(state_reg == ST_FETCH && vec_reg == VEC_EXT && !ext_set && !core_reset_reg)
		|=> !ext_request_flag_reg) else $error("latch not cleared at external fetch");
	AST_EDGE_ONCE: assert property (
		(!opt_reg[OPT_LEVEL_BIT] && !ext_request_flag_reg && comb_prev_reg && comb_req)
		|=> !ext_request_flag_reg) else $error("edge mode latched without a new edge");
	AST_LEVEL_HOLDS: assert property (
		(opt_reg[OPT_LEVEL_BIT] && comb_req && !sys_rst_i && !core_reset_reg)
		|=> ext_request_flag_reg) else $error("level request not held in latch");
endmodule : irq_seq
`default_nettype wire

// [irq_seq_pkg.sv]
`default_nettype none
package irq_seq_pkg;
	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [3:0]  ADDR_ISC       = 4'h0;
	localparam logic [3:0]  ADDR_OPT       = 4'h4;
	localparam logic [3:0]  ADDR_STAT      = 4'h8;
	localparam int          ISC_EN_BIT     = 0;
	localparam int          ISC_FLAG_BIT   = 1;
	localparam int          ISC_CLR_BIT    = 2;
	localparam int          OPT_LEVEL_BIT  = 0;
	localparam int          OPT_PORT_BIT   = 1;
	localparam int          OPT_WD_BIT     = 2;
	localparam int          STAT_MASK_BIT  = 0;
	localparam int          STAT_BUSY_BIT  = 1;
	localparam logic [2:0]  OPT_RESET      = 3'h0;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	// ************************************************************
	// Vectors (address of the high byte of each pair) and stacking
	// ************************************************************
	localparam logic [12:0] VEC_RESET      = 13'h1ffe;
	localparam logic [12:0] VEC_TRAP       = 13'h1ffc;
	localparam logic [12:0] VEC_EXT        = 13'h1ffa;
	localparam logic [12:0] VEC_CTMR       = 13'h1ff8;
	localparam logic [12:0] VEC_PTMR       = 13'h1ff6;
	localparam logic [12:0] VEC_SER        = 13'h1ff4;
	localparam logic [12:0] VEC_ANA        = 13'h1ff2;
	localparam logic [2:0]  STACK_BYTES    = 3'h5;

	typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_FETCH, ST_POP} seq_state_e;

	typedef struct packed {
		logic        push;
		logic        pop;
		logic        fetch;
		logic [12:0] vec_addr;
	} core_cmd_s;

	typedef struct packed {
		logic core_timer;
		logic prog_timer;
		logic serial;
		logic analog;
	} periph_req_s;
endpackage : irq_seq_pkg
`default_nettype wire

// [ext_src_model.sv]
`default_nettype none
module ext_src_model (
	input  wire logic       pin_low_i,
	input  wire logic [3:0] port_high_i,
	output logic            request_n_o,
	output logic [3:0]      port_pins_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********************************************************
	// Wired-OR sources; released lines settle at their pull level
	// ********************************************************
	// Request line idles high through its pull-up
	assign request_n_o = ~pin_low_i;
	// Port lines idle low through their pull-downs
	assign port_pins_o = port_high_i;
endmodule : ext_src_model
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb
	import irq_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LIMIT = 20000;
	logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pin_low, req_n, inst_done;
	logic        trap, ret, clear_mask_instruction, saved_mask, core_reset, gmask, busy;
	logic [3:0]  awaddr, araddr, port_high, port_pins;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [4:0]  rst_src;
	periph_req_s periph;
	core_cmd_s   cmd;
	int          bad_count, n_compared, cycles;

	ext_src_model u_src (.pin_low_i(pin_low), .port_high_i(port_high),
		.request_n_o(req_n), .port_pins_o(port_pins));
	irq_seq #(.PORT_PINS(4)) u_dut (
		.clk_sys_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.power_on_i(rst_src[0]), .reset_pin_n_i(~rst_src[1]), .low_voltage_i(rst_src[2]),
		.illegal_addr_i(rst_src[3]), .watchdog_timeout_i(rst_src[4]),
		.ext_request_n_i(req_n), .port_request_pins_i(port_pins), .periph_req_i(periph),
		.inst_done_i(inst_done), .software_trap_i(trap), .return_from_trap_i(ret),
		.clear_mask_instruction_i(clear_mask_instruction), .saved_mask_i(saved_mask),
		.core_reset_o(core_reset), .core_cmd_o(cmd), .global_mask_o(gmask), .busy_o(busy)
	);

	// ********************************************************
	// Access tasks
	// ********************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk

	task automatic conclude();
		if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude

	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, da, dw;
		da = 1'b0;
		dw = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(da && dw)) begin
			@(negedge clk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			@(posedge clk);
			da = da || ta;
			dw = dw || tw;
			awvalid <= !da;
			wvalid <= !dw;
		end
		do @(negedge clk); while (bvalid !== 1'b1);
		chk({30'h0, bresp}, {30'h0, er});
		@(posedge clk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge clk); while (arready !== 1'b1);
		@(posedge clk);
		arvalid <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
		@(posedge clk);
		rready <= 1'b0;
	endtask : rd

	// One instruction boundary with its qualifiers
	task automatic step(input logic t, input logic r, input logic c, input logic sm);
		@(posedge clk);
		inst_done <= 1'b1;
		trap <= t;
		ret <= r;
		clear_mask_instruction <= c;
		saved_mask <= sm;
		@(posedge clk);
		inst_done <= 1'b0;
	endtask : step

	// Counts sequencer commands over a window long enough for one entry
	task automatic watch(input int np, input int nq, input int nf, input logic [12:0] v);
		logic [31:0] p, q, f;
		logic [12:0] got;
		p = '0;
		q = '0;
		f = '0;
		got = '0;
		repeat (10) begin
			@(negedge clk);
			p = p + cmd.push;
			q = q + cmd.pop;
			f = f + cmd.fetch;
			if (cmd.fetch === 1'b1) got = cmd.vec_addr;
		end
		chk(p, np);
		chk(q, nq);
		chk(f, nf);
		chk(got, v);
		chk(busy, 0);
	endtask : watch

	task automatic drive(input logic pl, input logic [3:0] ph, input int n);
		@(posedge clk);
		pin_low <= pl;
		port_high <= ph;
		repeat (n) @(posedge clk);
	endtask : drive

	// ********************************************************
	// Clock, timeout and tests
	// ********************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			bad_count++;
			conclude();
		end
	end

	initial begin
		{rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
		{pin_low, inst_done, trap, ret, clear_mask_instruction, saved_mask} = 6'h0;
		{awaddr, araddr, port_high, wdata, rst_src} = '0;
		periph = '0;
		bad_count = 0;
		n_compared = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		watch(0, 0, 1, VEC_RESET);
		chk(core_reset, 0);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		rd(ADDR_OPT, 32'h0, RESP_OKAY);
		rd(ADDR_STAT, 32'h1, RESP_OKAY);
		rd(4'hc, 32'h0, RESP_SLVERR);
		wr(4'hc, 32'h1, RESP_SLVERR);
		// Edge and level mode: latched while masked, cleared only by a one
		drive(1, 4'h0, 4);
		drive(0, 4'h0, 4);
		rd(ADDR_ISC, 32'h3, RESP_OKAY);
		step(0, 0, 0, 0);
		watch(0, 0, 0, 13'h0);
		wr(ADDR_ISC, 32'h1, RESP_OKAY);
		rd(ADDR_ISC, 32'h3, RESP_OKAY);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		drive(1, 4'h0, 6);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		drive(1, 4'h0, 6);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		wr(ADDR_OPT, 32'h1, RESP_OKAY);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		rd(ADDR_ISC, 32'h3, RESP_OKAY);
		drive(0, 4'h0, 6);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		wr(ADDR_OPT, 32'h0, RESP_OKAY);
		// Enable gating, entry, fresh request during the handler
		wr(ADDR_ISC, 32'h0, RESP_OKAY);
		step(0, 0, 1, 0);
		watch(0, 0, 0, 13'h0);
		chk(gmask, 0);
		drive(1, 4'h0, 4);
		drive(0, 4'h0, 4);
		step(0, 0, 0, 0);
		watch(0, 0, 0, 13'h0);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		drive(1, 4'h0, 4);
		drive(0, 4'h0, 4);
		step(0, 0, 0, 0);
		watch(5, 0, 1, VEC_EXT);
		chk(gmask, 1);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		drive(1, 4'h0, 4);
		drive(0, 4'h0, 4);
		rd(ADDR_ISC, 32'h3, RESP_OKAY);
		step(0, 1, 0, 0);
		watch(0, 5, 0, 13'h0);
		chk(gmask, 0);
		step(0, 0, 0, 0);
		watch(5, 0, 1, VEC_EXT);
		step(1, 0, 0, 0);
		watch(5, 0, 1, VEC_TRAP);
		step(0, 1, 0, 1);
		watch(0, 5, 0, 13'h0);
		chk(gmask, 1);
		// Priority among pending sources
		drive(1, 4'h0, 4);
		drive(0, 4'h0, 4);
		periph <= periph_req_s'(4'hf);
		step(0, 1, 0, 0);
		watch(0, 5, 0, 13'h0);
		step(0, 0, 0, 0);
		watch(5, 0, 1, VEC_EXT);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			periph <= periph_req_s'(4'hf >> i);
			step(0, 1, 0, 0);
			watch(0, 5, 0, 13'h0);
			step(0, 0, 0, 0);
			watch(5, 0, 1, VEC_CTMR - 13'(2 * i));
		end
		@(posedge clk);
		periph <= '0;
		step(0, 1, 0, 1);
		watch(0, 5, 0, 13'h0);
		// Port pins as extra sources
		wr(ADDR_OPT, 32'h2, RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_ISC, 32'h5, RESP_OKAY);
			drive(0, 4'h1 << i, 6);
			rd(ADDR_ISC, 32'h3, RESP_OKAY);
			drive(0, 4'h0, 4);
		end
		drive(0, 4'h1, 6);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		drive(1, 4'h1, 4);
		drive(0, 4'h3, 6);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		drive(1, 4'h0, 6);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		drive(1, 4'h2, 6);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		wr(ADDR_OPT, 32'h3, RESP_OKAY);
		drive(0, 4'h4, 6);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		rd(ADDR_ISC, 32'h3, RESP_OKAY);
		drive(0, 4'h0, 6);
		wr(ADDR_ISC, 32'h5, RESP_OKAY);
		// Reset sources; watchdog only with its option
		wr(ADDR_OPT, 32'h0, RESP_OKAY);
		rst_src <= 5'h10;
		repeat (4) @(negedge clk);
		chk(core_reset, 0);
		@(posedge clk);
		rst_src <= 5'h0;
		wr(ADDR_OPT, 32'h4, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			rst_src <= 5'h1 << i;
			repeat (3) @(negedge clk);
			chk(core_reset, 1);
			@(posedge clk);
			rst_src <= 5'h0;
			watch(0, 0, 1, VEC_RESET);
		end
		chk(gmask, 1);
		rd(ADDR_OPT, 32'h4, RESP_OKAY);
		rd(ADDR_ISC, 32'h1, RESP_OKAY);
		conclude();
	end
endmodule : tb
`default_nettype wire
